// *** flash_program_erase_protect.sv ***
// APB-attached program, erase and block-protect controller for the flash array.
`timescale 1ns/100ps
module flash_program_erase_protect
   import flash_pkg::*;
(
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   ce,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [flash_pkg::ADDR_W-1:0] paddr,
   input  wire logic [flash_pkg::DATA_W-1:0] pwdata,
   output logic [flash_pkg::DATA_W-1:0] prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic [7:0]             arr_rdata,
   output logic [flash_pkg::ADDR_W-1:0] arr_addr,
   output logic [7:0]                  arr_wdata,
   output logic                        arr_rd,
   output logic                        arr_prog,
   output logic                        arr_erase,
   output logic                        arr_mass,
   output logic                        pump_on,
   output logic                        array_hv
);
   import flash_pkg::*;

   logic [DATA_W-1:0] prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [15:0]       arr_addr_r;
   logic [7:0]        arr_wdata_r;
   logic              arr_rd_r;
   logic              arr_prog_r;
   logic              arr_erase_r;
   logic              arr_mass_r;
   logic              pgm_r;
   logic              era_r;
   logic              mass_r;
   logic              high_voltage_enable_r;
   logic              pgm_nxt;
   logic              era_nxt;
   logic              high_voltage_enable_nxt;
   logic [7:0]        prot_r;
   logic [15:0]       tgt_r;
   logic              tgt_ok_r;
   logic              tgt_ok_nxt;
   seq_e              seq_r;
   seq_e              seq_nxt;
   logic              setup;
   logic              acc;
   logic              wr;
   logic              rd;
   logic              is_ctrl;
   logic              is_arr;
   logic              unmapped;
   logic              hit_bus;
   logic              hit_arr;
   logic              hv_set_ok;
   logic              prog_ok;
   logic [7:0]        wd;

   // Bus phases: the slave acts on the first access cycle and answers a cycle later.
   assign setup    = psel && !penable;
   assign acc      = psel && penable && !pready_r;
   assign wr       = acc && pwrite;
   assign rd       = acc && !pwrite;
   assign wd       = pwdata[7:0];
   assign unmapped = !in_array(paddr);
   assign is_ctrl  = (paddr == CONTROL_OFS);
   assign is_arr   = !unmapped && !is_ctrl;

   flash_protect_range u_bus_range (
      .prot_byte (prot_r),
      .addr      (paddr),
      .hit       (hit_bus)
   );

   flash_protect_range u_arr_range (
      .prot_byte (prot_r),
      .addr      (arr_addr_r),
      .hit       (hit_arr)
   );

   // High voltage may only rise once the target was latched and found open.
   assign hv_set_ok = (pgm_r || era_r) && (seq_r == SEQ_ADDR) && tgt_ok_r;

   // A program byte must stay in the latched row and outside the guarded range.
   assign prog_ok = (seq_r == SEQ_HV) && pgm_r && high_voltage_enable_r && is_arr && !hit_bus
                    && (row_of(paddr) == row_of(tgt_r));

   always_comb begin
      pgm_nxt  = pgm_r;
      era_nxt  = era_r;
      high_voltage_enable_nxt = high_voltage_enable_r;
      if (wr && is_ctrl) begin
         // A write asking for both selects clears both rather than pick one.
         pgm_nxt  = wd[PGM_BIT] && !wd[ERASE_BIT] && !era_r;
         era_nxt  = wd[ERASE_BIT] && !wd[PGM_BIT] && !pgm_r;
         high_voltage_enable_nxt = wd[HIGH_VOLTAGE_ENABLE_BIT] && (high_voltage_enable_r || hv_set_ok);
      end
   end

   always_comb begin
      // Mass erase already selected when the target is latched also needs an open array, since it would wipe any range.
      tgt_ok_nxt = !hit_bus;
      if (era_r && mass_r && (prot_r != PROT_NONE)) begin
         tgt_ok_nxt = 1'b0;
      end
   end

   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         SEQ_IDLE: if (pgm_r || era_r) seq_nxt = SEQ_SEL;
         SEQ_SEL:  if (rd && paddr == PROTECT_OFS) seq_nxt = SEQ_PROT;
         SEQ_PROT: if (wr && is_arr) seq_nxt = SEQ_ADDR;
         SEQ_ADDR: if (high_voltage_enable_r) seq_nxt = SEQ_HV;
         SEQ_HV:   if (!high_voltage_enable_r) seq_nxt = SEQ_IDLE;
         default:  seq_nxt = SEQ_IDLE;
      endcase
      if (seq_r != SEQ_HV && !pgm_r && !era_r) begin
         seq_nxt = SEQ_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_r <= SEQ_IDLE;
      end else if (ce) begin
         seq_r <= seq_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pgm_r  <= CTRL_RESET;
         era_r  <= CTRL_RESET;
         mass_r <= CTRL_RESET;
         high_voltage_enable_r <= CTRL_RESET;
      end else if (ce) begin
         pgm_r  <= pgm_nxt;
         era_r  <= era_nxt;
         high_voltage_enable_r <= high_voltage_enable_nxt;
         if (wr && is_ctrl) begin
            mass_r <= wd[MASS_BIT];
         end
      end
   end

   // The protect copy is refreshed by the read that must precede high voltage.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot_r <= PROT_RESET;
      end else if (ce) begin
         if (rd && paddr == PROTECT_OFS) begin
            prot_r <= arr_rdata;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_r    <= USER_LO;
         tgt_ok_r <= 1'b0;
      end else if (ce) begin
         if (seq_r == SEQ_PROT && wr && is_arr) begin
            tgt_r    <= paddr;
            tgt_ok_r <= tgt_ok_nxt;
         end
      end
   end

   // Array port. Reads go out at setup so data is back by the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_addr_r  <= USER_LO;
         arr_wdata_r <= ERASED_BYTE;
         arr_rd_r    <= 1'b0;
         arr_prog_r  <= 1'b0;
      end else if (ce) begin
         arr_rd_r   <= 1'b0;
         arr_prog_r <= 1'b0;
         if (setup && !pwrite && is_arr && !arr_erase_r) begin
            arr_rd_r   <= 1'b1;
            arr_addr_r <= paddr;
         end else if (seq_r == SEQ_PROT && wr && is_arr) begin
            arr_addr_r <= paddr;
         end else if (wr && prog_ok) begin
            // Programming clears bits only; an erased byte reads back as all ones.
            arr_prog_r  <= 1'b1;
            arr_addr_r  <= paddr;
            arr_wdata_r <= wd;
         end
      end
   end

   // Erase runs only while high voltage is up on an open target; erasing the
   // top page also wipes the protect byte, which shares it with the vectors.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arr_erase_r <= 1'b0;
         arr_mass_r  <= 1'b0;
      end else if (ce) begin
         arr_erase_r <= (seq_r == SEQ_HV) && era_r && high_voltage_enable_r && tgt_ok_r;
         arr_mass_r  <= (seq_r == SEQ_HV) && era_r && high_voltage_enable_r && tgt_ok_r
                        && mass_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else if (ce) begin
         if (pready_r && psel && penable) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
         end else if (acc) begin
            pready_r  <= 1'b1;
            pslverr_r <= unmapped;
            prdata_r  <= '0;
            if (rd && is_ctrl) begin
               prdata_r[PGM_BIT]   <= pgm_r;
               prdata_r[ERASE_BIT] <= era_r;
               prdata_r[MASS_BIT]  <= mass_r;
               prdata_r[HIGH_VOLTAGE_ENABLE_BIT]  <= high_voltage_enable_r;
            end else if (rd && is_arr) begin
               prdata_r[7:0] <= arr_rdata;
            end
         end
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign arr_addr  = arr_addr_r;
   assign arr_wdata = arr_wdata_r;
   assign arr_rd    = arr_rd_r;
   assign arr_prog  = arr_prog_r;
   assign arr_erase = arr_erase_r;
   assign arr_mass  = arr_mass_r;
   // The pump and array high voltage come straight from the enable bit.
   assign pump_on   = high_voltage_enable_r;
   assign array_hv  = high_voltage_enable_r;

   a_hv_needs_sel: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(high_voltage_enable_r) |-> (pgm_r || era_r) && $past(seq_r) == SEQ_ADDR)
      else $error("high voltage rose without a selected operation");

   a_hv_open_tgt: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(high_voltage_enable_r) |-> tgt_ok_r)
      else $error("high voltage rose on a protected target");

   a_sel_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
      !(pgm_r && era_r))
      else $error("program and erase selected together");

   a_pump_on_work: assert property (@(posedge pclk) disable iff (!presetn)
      (arr_prog || arr_erase) |-> pump_on && array_hv)
      else $error("array work without high voltage");

   // The erase outputs are registered, so they follow the select bit one cycle late.
   a_mass_select: assert property (@(posedge pclk) disable iff (!presetn)
      arr_mass |-> arr_erase && $past(mass_r))
      else $error("mass erase without whole-array select");

   a_prog_open: assert property (@(posedge pclk) disable iff (!presetn)
      arr_prog |-> !hit_arr)
      else $error("programmed a protected byte");

   a_prog_row: assert property (@(posedge pclk) disable iff (!presetn)
      arr_prog |-> row_of(arr_addr_r) == row_of(tgt_r))
      else $error("programmed outside the latched row");

   a_erase_guard: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(arr_erase) |-> tgt_ok_r && $past(high_voltage_enable_r) && $past(era_r))
      else $error("erase started on a refused target");

   a_top_pair: assert property (@(posedge pclk) disable iff (!presetn)
      (prot_r == PROT_TOP2 && arr_addr_r >= PROT_TOP2_START) |-> hit_arr)
      else $error("top two pages not guarded");

   a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (acc && ce) |=> pready_r)
      else $error("bus access not answered");

endmodule : flash_program_erase_protect

// *** flash_pkg.sv ***
// Shared constants, state codes and address helpers for the flash sequencer.
package flash_pkg;

   localparam int          ADDR_W          = 16;
   localparam int          DATA_W          = 32;
   localparam int          BYTE_W          = 8;

   // Array map, byte addresses.
   localparam logic [15:0] USER_LO         = 16'h8000;
   localparam logic [15:0] USER_HI         = 16'hFDFF;
   localparam logic [15:0] PROTECT_OFS     = 16'hFF80;
   localparam logic [15:0] CONTROL_OFS     = 16'hFF88;
   localparam logic [15:0] VECTOR_LO       = 16'hFFCC;
   localparam logic [15:0] ARRAY_TOP       = 16'hFFFF;

   // Page and row geometry.
   localparam int          ROW_BYTES       = 64;
   localparam int          PAGE_BYTES      = 128;
   localparam int          ROW_LSB         = 6;
   localparam int          PAGE_LSB        = 7;

   // Control register fields.
   localparam int          PGM_BIT         = 0;
   localparam int          ERASE_BIT       = 1;
   localparam int          MASS_BIT        = 2;
   localparam int          HIGH_VOLTAGE_ENABLE_BIT        = 3;
   localparam logic        CTRL_RESET      = 1'b0;

   // Protect byte decoding.
   localparam logic [7:0]  PROT_RESET      = 8'h00;
   localparam logic [7:0]  PROT_NONE       = 8'hFF;
   localparam logic [7:0]  PROT_TOP2       = 8'hFE;
   localparam logic [15:0] PROT_TOP2_START = 16'hFF00;
   localparam logic [7:0]  ERASED_BYTE     = 8'hFF;

   typedef enum logic [4:0] {
      SEQ_IDLE = 5'b0_0001,
      SEQ_SEL  = 5'b0_0010,
      SEQ_PROT = 5'b0_0100,
      SEQ_ADDR = 5'b0_1000,
      SEQ_HV   = 5'b1_0000
   } seq_e;

   function automatic logic [9:0] row_of(input logic [15:0] a);
      row_of = a[15:ROW_LSB];
   endfunction : row_of

   function automatic logic [8:0] page_of(input logic [15:0] a);
      page_of = a[15:PAGE_LSB];
   endfunction : page_of

   function automatic logic in_array(input logic [15:0] a);
      in_array = (a >= USER_LO);
   endfunction : in_array

endpackage : flash_pkg

// *** flash_protect_range.sv ***
// Decides whether an array address falls inside the range set by the protect byte.
`timescale 1ns/100ps
module flash_protect_range
   import flash_pkg::*;
(
   input  wire logic [7:0]  prot_byte,
   input  wire logic [15:0] addr,
   output logic             hit
);
   logic [15:0] start;

   always_comb begin
      // The start is the protect byte placed at bits 14..7 with bit 15 set.
      start = {1'b1, prot_byte, 7'b000_0000};
      if (prot_byte == PROT_TOP2) begin
         start = PROT_TOP2_START;
      end
   end

   // All ones leaves the array open; anything else guards start to the top.
   assign hit = (prot_byte != PROT_NONE) && (addr >= start);

endmodule : flash_protect_range

// *** flash_array_model.sv ***
// Behavioural flash array that answers the sequencer's array port.
`timescale 1ns/100ps
module flash_array_model (
   input  wire logic        pclk,
   input  wire logic [15:0] arr_addr,
   input  wire logic [7:0]  arr_wdata,
   input  wire logic        arr_rd,
   input  wire logic        arr_prog,
   input  wire logic        arr_erase,
   input  wire logic        arr_mass,
   input  wire logic        array_hv,
   output logic [7:0]       arr_rdata
);
   logic [7:0]  mem [16'h8000:16'hFFFF];
   logic [7:0]  last;
   // Data answers while the read strobe stands, since the sequencer captures it then.
   // Outside a strobe the lines show the inverse, so stale data never passes.
   assign arr_rdata = arr_rd ? mem[arr_addr] : ~last;
   initial begin
      last = 8'h00;
      foreach (mem[i]) mem[i] = 8'hFF;
   end
   task automatic poke(input logic [15:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask : poke
   always @(posedge pclk) begin
      if (arr_rd) last <= mem[arr_addr];
      if (arr_prog && array_hv) mem[arr_addr] <= mem[arr_addr] & arr_wdata;
      // The protect byte is an ordinary cell, so an open top page erase clears it too.
      if (arr_erase && array_hv) begin
         foreach (mem[i]) begin
            if (arr_mass || (i >> 7) == int'(arr_addr >> 7)) mem[i] <= 8'hFF;
         end
      end
   end
endmodule : flash_array_model

// *** flash_program_erase_protect_tb.sv ***
// Self-checking bench for the flash program, erase and protect sequencer.
`timescale 1ns/100ps
module flash_program_erase_protect_tb;
   import flash_pkg::*;
   typedef struct {logic wr; logic [15:0] a; logic [7:0] d; logic [7:0] exp; logic err;} row_s;
   typedef struct {logic [7:0] p; logic [15:0] a; logic m; logic ok;} prot_s;
   logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er;
   logic        arr_rd, arr_prog, arr_erase, arr_mass, pump_on, array_hv;
   logic [15:0] paddr, arr_addr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  arr_rdata, arr_wdata;
   int          err_count, comparisons;
   int          lat_exp;
   row_s rows [0:15] = '{
      '{1'b0, CONTROL_OFS, 8'h00, 8'h00, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h01, 8'h00, 1'b0},
      '{1'b0, CONTROL_OFS, 8'h00, 8'h01, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h03, 8'h00, 1'b0},
      '{1'b0, CONTROL_OFS, 8'h00, 8'h00, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h02, 8'h00, 1'b0},
      '{1'b0, CONTROL_OFS, 8'h00, 8'h02, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h06, 8'h00, 1'b0},
      '{1'b0, CONTROL_OFS, 8'h00, 8'h06, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h0E, 8'h00, 1'b0},
      '{1'b0, CONTROL_OFS, 8'h00, 8'h06, 1'b0},
      '{1'b1, CONTROL_OFS, 8'h00, 8'h00, 1'b0},
      '{1'b1, PROTECT_OFS, 8'h00, 8'h00, 1'b0},
      '{1'b0, PROTECT_OFS, 8'h00, 8'hFF, 1'b0},
      '{1'b0, 16'h1000,    8'h00, 8'h00, 1'b1},
      '{1'b1, 16'h1000,    8'h5A, 8'h00, 1'b1}};
   prot_s prots [0:11] = '{
      '{8'hFF, 16'hFF00, 1'b0, 1'b1},
      '{8'hFE, 16'hFE80, 1'b0, 1'b1},
      '{8'hFE, 16'hFF00, 1'b0, 1'b0},
      '{8'hFD, 16'hFE00, 1'b0, 1'b1},
      '{8'hFD, 16'hFE80, 1'b0, 1'b0},
      '{8'h08, 16'h8380, 1'b0, 1'b1},
      '{8'h08, 16'h8400, 1'b0, 1'b0},
      '{8'h00, 16'h8000, 1'b0, 1'b0},
      '{8'hFF, 16'h8000, 1'b1, 1'b1},
      '{8'h08, 16'h8000, 1'b1, 1'b0},
      '{8'hFE, 16'hFF00, 1'b1, 1'b0},
      '{8'hFF, 16'hFFCC, 1'b0, 1'b1}};

   flash_program_erase_protect uut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .arr_rdata(arr_rdata), .arr_addr(arr_addr),
      .arr_wdata(arr_wdata), .arr_rd(arr_rd), .arr_prog(arr_prog),
      .arr_erase(arr_erase), .arr_mass(arr_mass), .pump_on(pump_on),
      .array_hv(array_hv));
   flash_array_model mdl (
      .pclk(pclk), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rd(arr_rd),
      .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_mass(arr_mass),
      .array_hv(array_hv), .arr_rdata(arr_rdata));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic results;
      if (err_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : results

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_flag(input logic got, input logic exp);
      chk_data({31'h0000_0000, got}, {31'h0000_0000, exp});
   endtask : chk_flag

   // The request is held until pready is seen high at a rising edge.
   // The master runs outside the array and takes no interrupts.
   task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      chk_data(n, lat_exp);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
      apb(1'b1, CONTROL_OFS, 8'h01);
      apb(1'b0, PROTECT_OFS, 8'h00);
      apb(1'b1, a, 8'hFF);
      apb(1'b1, CONTROL_OFS, 8'h09);
      apb(1'b1, a, d);
      apb(1'b1, CONTROL_OFS, 8'h08);
      apb(1'b1, CONTROL_OFS, 8'h00);
   endtask : prog_byte

   task automatic erase(input prot_s t);
      logic [7:0] sel;
      sel = t.m ? 8'h06 : 8'h02;
      mdl.poke(PROTECT_OFS, t.p);
      mdl.poke(t.a, 8'h00);
      apb(1'b1, CONTROL_OFS, sel);
      apb(1'b0, PROTECT_OFS, 8'h00);
      apb(1'b1, t.a, 8'h00);
      apb(1'b1, CONTROL_OFS, sel | 8'h08);
      apb(1'b0, CONTROL_OFS, 8'h00);
      chk_data(rd, {24'h00_0000, t.ok ? (sel | 8'h08) : sel});
      chk_flag(pump_on, t.ok);
      chk_flag(array_hv, t.ok);
      apb(1'b1, CONTROL_OFS, 8'h08);
      apb(1'b1, CONTROL_OFS, 8'h00);
      chk_flag(pump_on, 1'b0);
      apb(1'b0, t.a, 8'h00);
      chk_data(rd, t.ok ? 32'h0000_00FF : 32'h0000_0000);
   endtask : erase

   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      results();
   end

   initial begin
      err_count = 0;
      comparisons = 0;
      lat_exp = 2;
      presetn = 1'b0;
      ce = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].a, rows[i].d);
         chk_flag(er, rows[i].err);
         if (!rows[i].wr) chk_data(rd, {24'h00_0000, rows[i].exp});
      end
      prog_byte(16'h8041, 8'h5A);
      apb(1'b0, 16'h8041, 8'h00);
      chk_data(rd, 32'h0000_005A);
      chk_data({16'h0000, arr_addr}, 32'h0000_8041);
      chk_data({24'h00_0000, arr_wdata}, 32'h0000_005A);
      foreach (prots[i]) erase(prots[i]);
      // Clock enable low freezes the slave, so the answer slips by one frozen access edge.
      ce <= 1'b0;
      lat_exp = 3;
      fork
         apb(1'b1, CONTROL_OFS, 8'h04);
         begin
            repeat (3) @(posedge pclk);
            ce <= 1'b1;
         end
      join
      lat_exp = 2;
      apb(1'b0, CONTROL_OFS, 8'h00);
      chk_data(rd, 32'h0000_0004);
      // Reset in the middle of an erase must drop high voltage at once.
      mdl.poke(PROTECT_OFS, 8'hFF);
      apb(1'b1, CONTROL_OFS, 8'h02);
      apb(1'b0, PROTECT_OFS, 8'h00);
      apb(1'b1, 16'h8000, 8'h00);
      apb(1'b1, CONTROL_OFS, 8'h0A);
      repeat (3) @(posedge pclk);
      chk_flag(arr_erase, 1'b1);
      chk_flag(arr_mass, 1'b0);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk_flag(pump_on, 1'b0);
      chk_flag(arr_erase, 1'b0);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, CONTROL_OFS, 8'h00);
      chk_data(rd, 32'h0000_0000);
      results();
   end
endmodule : flash_program_erase_protect_tb
